// >>> sim/mlr_exec_asserts.sv
// mlr_exec_asserts: port properties of the execution unit.
// assumes: bound to mlr_exec from tb; a single pclk domain.
`timescale 1ns/1ps
`default_nettype none
module mlr_exec_asserts
    import mlr_pkg::*;
#(
    parameter int PC_W = 11                      // pc width
)(
    input wire logic             pclk,           // clock
    input wire logic             presetn,        // reset, low
    input wire mlr_pkg::mlr_op_t instr_op,       // op
    input wire logic             instr_valid,    // offered
    input wire logic [7:0]       instr_imm,      // constant
    input wire logic             instr_ready,    // accepting
    input wire logic [7:0]       mem_rdata,      // memory byte
    input wire logic             mem_we,         // write pulse
    input wire logic [7:0]       mem_wdata,      // write byte
    input wire logic [PC_W-1:0]  stack_top,      // return address
    input wire logic             stack_pop,      // pop pulse
    input wire logic [PC_W-1:0]  pc,             // program counter
    input wire logic [7:0]       acc,            // working register
    input wire logic [3:0]       flags,          // ov z ac c
    input wire logic             gie             // interrupt enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire take = instr_valid && instr_ready;
    chk_copy_keep: assert property (
        take && instr_op == OP_COPY_MEM_TO_W |=> acc == $past(mem_rdata)
        && flags == $past(flags)) else $error("copy to acc wrong");
    chk_store_acc: assert property (
        take && instr_op == OP_COPY_W_TO_MEM |=> mem_we
        && mem_wdata == $past(acc)) else $error("store of acc wrong");
    chk_idle_step: assert property (
        take && instr_op == OP_IDLE_INSTRUCTION |=> !mem_we && instr_ready
        && pc == PC_W'($past(pc) + 1)) else $error("idle step wrong");
    chk_or_zero: assert property (
        take && instr_op == OP_OR_IMM |=> acc == $past(acc | instr_imm)
        && flags[FLAG_Z] == (acc == 8'h00)) else $error("or result wrong");
    chk_exit_dummy: assert property (
        take && instr_op inside {OP_SUBROUTINE_EXIT, OP_SUB_EXIT_VALUE,
        OP_INTERRUPT_EXIT} |=> stack_pop && !instr_ready
        && pc == $past(stack_top) ##1 !stack_pop && instr_ready)
        else $error("exit timing wrong");
    chk_interrupt_exit_gie: assert property (
        take && instr_op == OP_INTERRUPT_EXIT |=> gie)
        else $error("interrupt enable not set");
    chk_rot_left: assert property (
        take && instr_op == OP_ROT_L |=> mem_we && mem_wdata ==
        {$past(mem_rdata[6:0]), $past(mem_rdata[7])}) else $error("rotate");
    chk_skip_zero: assert property (
        take && instr_op == OP_DEC_SKIP_ZERO && mem_rdata == 8'h01 |=> mem_we
        && mem_wdata == 8'h00 && !instr_ready && pc == PC_W'($past(pc) + 2))
        else $error("skip on zero wrong");
endmodule // mlr_exec_asserts
`default_nettype wire

// >>> sim/tb.sv
// tb: self-checking bench for mlr_exec; op table, then skips and exits.
// assumes: mlr_pkg and the checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mlr_pkg::*;
    localparam int PW = 11;
    typedef struct packed {
        mlr_op_t    op;
        logic [7:0] imm, mem, a0;
        logic [3:0] f0;
        logic [7:0] a1;
        logic [3:0] f1, we;
        logic [7:0] wd;
    } mlr_row_t;
    // fields after op: imm mem acc0 flg0 acc1 flg1 we wdata
    mlr_row_t rows [20] = '{
        {OP_IDLE_INSTRUCTION, 52'h00_5A_3C_F_3C_F_0_00},
        {OP_COPY_MEM_TO_W,    52'h00_A5_00_F_A5_F_0_00},
        {OP_COPY_IMM_TO_W,    52'h7E_11_00_5_7E_5_0_00},
        {OP_COPY_W_TO_MEM,    52'h00_00_C3_A_C3_A_1_C3},
        {OP_OR_MEM,           52'h00_00_00_0_00_4_0_00},
        {OP_OR_IMM,           52'h01_00_10_F_11_B_0_00},
        {OP_OR_INTO_MEMORY,   52'h00_0F_F0_0_F0_0_1_FF},
        {OP_ROT_L,            52'h00_81_00_0_00_0_1_03},
        {OP_ROT_L_W,          52'h00_81_00_F_03_F_0_00},
        {OP_ROT_LC,           52'h00_80_00_4_00_5_1_00},
        {OP_ROT_LC_W,         52'h00_01_00_1_03_0_0_00},
        {OP_ROT_R,            52'h00_01_00_0_00_0_1_80},
        {OP_ROT_R_W,          52'h00_02_00_F_01_F_0_00},
        {OP_ROT_RC,           52'h00_01_00_0_00_1_1_00},
        {OP_ROT_RC_W,         52'h00_02_00_1_81_0_0_00},
        {OP_SUB_BORROW,       52'h00_01_10_1_0F_1_0_00},
        {OP_SUB_BORROW,       52'h00_00_00_1_00_7_0_00},
        {OP_SUB_BORROW_MEM,   52'h00_01_80_1_80_9_1_7F},
        {OP_DEC_SKIP_ZERO,    52'h00_05_00_F_00_F_1_04},
        {OP_DEC_W_SKIP_ZERO,  52'h00_10_00_F_0F_F_0_00}
    };
    logic          pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic          penable = 1'b0, pwrite = 1'b0, instr_valid = 1'b0;
    logic          pready, pslverr, instr_ready, mem_we, stack_pop, gie, er;
    logic [31:0]   paddr = '0, pwdata = '0, prdata, rd;
    mlr_op_t       instr_op = OP_IDLE_INSTRUCTION;
    logic [7:0]    instr_imm = '0, mem_rdata = '0, mem_wdata, acc;
    logic [PW-1:0] stack_top = '0, pc, pc0;
    logic [3:0]    flags;
    int            bad_count = 0, check_count = 0, cyc = 0;
    mlr_op_t       ex_op [3] = '{OP_SUBROUTINE_EXIT, OP_SUB_EXIT_VALUE,
                                 OP_INTERRUPT_EXIT};
    logic [31:0]   ra [5] = '{REG_CTRL, REG_STATUS, REG_ACC, REG_FLAGS, REG_PC};
    logic [31:0]   re [5] = '{32'h1, 32'h1, 32'h0, 32'h0, 32'h0};

    mlr_exec #(.PC_W(PW)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid),
        .instr_op(instr_op), .instr_imm(instr_imm),
        .instr_ready(instr_ready), .mem_rdata(mem_rdata), .mem_we(mem_we),
        .mem_wdata(mem_wdata), .stack_top(stack_top),
        .stack_pop(stack_pop), .pc(pc), .acc(acc), .flags(flags), .gie(gie)
    );
    always #50 pclk = ~pclk;

    task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // request held until the edge that ends the access phase
    task automatic apb(logic wr, logic [31:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // offer one op; returns mid-cycle after the accepting edge
    task automatic issue(mlr_op_t op, logic [7:0] im, mv, logic [PW-1:0] st);
        @(negedge pclk);
        while (instr_ready !== 1'b1) @(negedge pclk);
        pc0 = pc;
        @(posedge pclk);
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_imm <= im;
        mem_rdata <= mv;
        stack_top <= st;
        @(posedge pclk);
        instr_valid <= 1'b0;
        mem_rdata <= ~mv;
        @(negedge pclk);
    endtask

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            bad_count++;
            stop_test();
        end
    end

    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i])
        begin
            apb(1'b0, ra[i], 32'h0);
            check("reset value", re[i], rd);
        end
        apb(1'b0, 32'h20, 32'h0);
        check("unmapped err", 1'b1, er);
        foreach (rows[i])
        begin
            apb(1'b1, REG_ACC, {24'h0, rows[i].a0});
            apb(1'b1, REG_FLAGS, {28'h0, rows[i].f0});
            issue(rows[i].op, rows[i].imm, rows[i].mem, '0);
            check("acc", rows[i].a1, acc);
            check("flags", rows[i].f1, flags);
            check("mem_we", rows[i].we, mem_we);
            check("wdata", rows[i].wd, mem_wdata);
            check("pc", PW'(pc0 + 1'b1), pc);
        end
        issue(OP_DEC_SKIP_ZERO, 8'h00, 8'h01, '0);
        check("skip pc", PW'(pc0 + 2'd2), pc);
        check("skip wdata", 8'h00, mem_wdata);
        check("dummy ready", 1'b0, instr_ready);
        @(negedge pclk);
        check("ready back", 1'b1, instr_ready);
        issue(OP_DEC_W_SKIP_ZERO, 8'h00, 8'h01, '0);
        check("skipw acc", 8'h00, acc);
        check("skipw mem_we", 1'b0, mem_we);
        check("skipw pc", PW'(pc0 + 2'd2), pc);
        apb(1'b1, REG_FLAGS, 32'hF);
        foreach (ex_op[i])
        begin
            issue(ex_op[i], 8'h5A, 8'h00, PW'(11'h120 + i));
            check("exit pc", 11'h120 + i, pc);
            check("exit pop", 1'b1, stack_pop);
            check("exit ready", 1'b0, instr_ready);
            check("exit acc", (i > 0) ? 8'h5A : 8'h00, acc);
            check("exit flags", 4'hF, flags);
            check("gie", i == 2, gie);
        end
        apb(1'b0, REG_STATUS, 32'h0);
        check("status", 32'h5, rd);
        // software stop: no op may be taken while run is low
        apb(1'b1, REG_CTRL, 32'h0);
        @(negedge pclk);
        check("run off", 1'b0, instr_ready);
        check("gie clear", 1'b0, gie);
        // mid-run reset brings run back and clears the pc
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        check("rst pc", 11'h000, pc);
        presetn <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h0);
        check("rst ctrl", 32'h1, rd);
        stop_test();
    end
endmodule // tb

bind mlr_exec mlr_exec_asserts #(.PC_W(PC_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .instr_op(instr_op),
    .instr_valid(instr_valid), .instr_imm(instr_imm),
    .instr_ready(instr_ready), .mem_rdata(mem_rdata), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .stack_top(stack_top), .stack_pop(stack_pop),
    .pc(pc), .acc(acc), .flags(flags), .gie(gie)
);
`default_nettype wire

// >>> verilog/mlr_alu.sv
// mlr_alu: combinational datapath for the move/or/rotate/subtract ops.
// assumes: operand byte is the addressed data memory byte, same cycle.
`timescale 1ns/1ps
`default_nettype none
module mlr_alu
    import mlr_pkg::*;
(
    input  wire mlr_pkg::mlr_op_t op,          // decoded operation
    input  wire logic [7:0]       acc,         // working register
    input  wire logic [7:0]       mem,         // addressed memory byte
    input  wire logic [7:0]       imm,         // instruction constant
    input  wire logic [3:0]       flags_in,    // current flags
    output var  logic [7:0]       result,      // value to store
    output var  logic [3:0]       flags_out,   // flags after op
    output var  logic             w_we,        // result to working reg
    output var  logic             m_we,        // result to memory
    output var  logic             zero_skip    // decrement result is zero
);
    // ----------------------------------------------------------------
    // subtract with borrow: acc + ~mem + carry
    // ----------------------------------------------------------------
    wire logic       c_in   = flags_in[FLAG_C];
    wire logic [7:0] mem_n  = ~mem;
    wire logic [4:0] lo_sum = {1'b0, acc[3:0]} + {1'b0, mem_n[3:0]}
                              + {4'h0, c_in};
    wire logic [3:0] hi7    = {1'b0, acc[6:4]} + {1'b0, mem_n[6:4]}
                              + {3'h0, lo_sum[NIB_W]};
    wire logic [8:0] full   = {1'b0, acc} + {1'b0, mem_n} + {8'h00, c_in};
    wire logic [7:0] dec    = mem - 8'h01;

    always_comb
    begin
        result    = acc;
        flags_out = flags_in;
        w_we      = 1'b0;
        m_we      = 1'b0;
        zero_skip = 1'b0;
        case (op)
            OP_COPY_MEM_TO_W:
            begin
                result = mem; w_we = 1'b1;
            end
            OP_COPY_IMM_TO_W, OP_SUB_EXIT_VALUE:
            begin
                result = imm; w_we = 1'b1;
            end
            OP_COPY_W_TO_MEM:
            begin
                result = acc; m_we = 1'b1;
            end
            OP_OR_MEM, OP_OR_IMM, OP_OR_INTO_MEMORY:
            begin
                result = acc | ((op == OP_OR_IMM) ? imm : mem);
                w_we   = (op != OP_OR_INTO_MEMORY);
                m_we   = (op == OP_OR_INTO_MEMORY);
                flags_out[FLAG_Z] = (result == 8'h00);
            end
            OP_ROT_L, OP_ROT_L_W:
            begin
                result = {mem[6:0], mem[BYTE_MSB]};
                w_we   = (op == OP_ROT_L_W);
                m_we   = (op == OP_ROT_L);
            end
            OP_ROT_LC, OP_ROT_LC_W:
            begin
                result = {mem[6:0], c_in};
                flags_out[FLAG_C] = mem[BYTE_MSB];
                w_we   = (op == OP_ROT_LC_W);
                m_we   = (op == OP_ROT_LC);
            end
            OP_ROT_R, OP_ROT_R_W:
            begin
                result = {mem[0], mem[BYTE_MSB:1]};
                w_we   = (op == OP_ROT_R_W);
                m_we   = (op == OP_ROT_R);
            end
            OP_ROT_RC, OP_ROT_RC_W:
            begin
                result = {c_in, mem[BYTE_MSB:1]};
                flags_out[FLAG_C] = mem[0];
                w_we   = (op == OP_ROT_RC_W);
                m_we   = (op == OP_ROT_RC);
            end
            OP_SUB_BORROW, OP_SUB_BORROW_MEM:
            begin
                result = full[7:0];
                flags_out[FLAG_C]  = full[8];
                flags_out[FLAG_AC] = lo_sum[NIB_W];
                flags_out[FLAG_Z]  = (full[7:0] == 8'h00);
                // overflow: carry into msb differs from carry out
                flags_out[FLAG_OV] = hi7[3] ^ full[8];
                w_we   = (op == OP_SUB_BORROW);
                m_we   = (op == OP_SUB_BORROW_MEM);
            end
            OP_DEC_SKIP_ZERO, OP_DEC_W_SKIP_ZERO:
            begin
                result    = dec;
                zero_skip = (dec == 8'h00);
                w_we      = (op == OP_DEC_W_SKIP_ZERO);
                m_we      = (op == OP_DEC_SKIP_ZERO);
            end
            default:
            begin
                result = acc;
            end
        endcase
    end
endmodule // mlr_alu
`default_nettype wire

// >>> verilog/mlr_exec.sv
// mlr_exec: execution unit for moves, or, returns, rotates, subtract
// with borrow and decrement-skip, with an apb window on its state.
// assumes: memory byte and stack top arrive combinationally on pclk;
// the return stack pops on stack_pop; memory writes on mem_we.
//
// Function
// - copy memory to working register, flags kept
// - copy immediate to working register, flags kept
// - copy working register to memory, flags kept
// - idle instruction only advances program counter
// - or into working register, zero flag only
// - or into memory, zero flag only
// - subroutine exit pops pc, two cycles
// - exit with value also loads working register
// - interrupt exit pops pc, sets interrupt enable
// - rotate memory left in place, no flags
// - rotate left into working register, no flags
// - rotate left through carry into memory
// - rotate left through carry into working register
// - rotate memory right in place, no flags
// - rotate right into working register, no flags
// - rotate right through carry into memory
// - rotate right through carry into working register
// - subtract with borrow into working register
// - subtract with borrow into memory
// - decrement memory, skip next when zero
// - decrement into working register, skip when zero
// - skip discards prefetch, adds dummy cycle
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mlr_exec
    import mlr_pkg::*;
#(
    parameter int PC_W = 11                          // program counter width
)(
    input  wire logic                   pclk,        // system clock
    input  wire logic                   presetn,     // async reset, low
    // apb slave
    input  wire logic                   psel,        // slave select
    input  wire logic                   penable,     // access phase
    input  wire logic                   pwrite,      // write when high
    input  wire logic [31:0]            paddr,       // byte address
    input  wire logic [31:0]            pwdata,      // write data
    output var  logic [31:0]            prdata,      // read data
    output var  logic                   pready,      // transfer done
    output var  logic                   pslverr,     // unmapped address
    // instruction side
    input  wire logic                   instr_valid, // op offered
    input  wire mlr_pkg::mlr_op_t       instr_op,    // decoded op
    input  wire logic [7:0]             instr_imm,   // immediate byte
    output var  logic                   instr_ready, // op taken at edge
    // data memory and stack
    input  wire logic [7:0]             mem_rdata,   // addressed byte
    output var  logic                   mem_we,      // write pulse
    output var  logic [7:0]             mem_wdata,   // write byte
    input  wire logic [PC_W-1:0]        stack_top,   // return address
    output var  logic                   stack_pop,   // pop pulse
    // core state
    output var  logic [PC_W-1:0]        pc,          // program counter
    output var  logic [7:0]             acc,         // working register
    output var  logic [3:0]             flags,       // ov z ac c
    output var  logic                   gie          // interrupt enable
);
    import mlr_pkg::*;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic is_exit(input mlr_op_t o);
        is_exit = (o == OP_SUBROUTINE_EXIT) || (o == OP_SUB_EXIT_VALUE)
                  || (o == OP_INTERRUPT_EXIT);
    endfunction

    function automatic logic is_skip_op(input mlr_op_t o);
        is_skip_op = (o == OP_DEC_SKIP_ZERO) || (o == OP_DEC_W_SKIP_ZERO);
    endfunction

    localparam logic [PC_W-1:0] PC_ONE = PC_W'(1);
    localparam logic [PC_W-1:0] PC_TWO = PC_W'(2);
    localparam logic [PC_W-1:0] PC_RST = '0;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    mlr_state_t        state_q, state_d;
    logic [PC_W-1:0]   pc_q, pc_d;
    logic [7:0]        acc_q, acc_d;
    logic [3:0]        flags_q, flags_d;
    logic              gie_q, gie_d;
    logic              run_q, run_d;
    logic              ready_q;
    logic              mem_we_q;
    logic [7:0]        mem_wdata_q;
    logic              pop_q;
    logic [31:0]       prdata_q;
    logic              pready_q;
    logic              pslverr_q;

    // ----------------------------------------------------------------
    // datapath
    // ----------------------------------------------------------------
    logic [7:0] alu_res;
    logic [3:0] alu_flags;
    logic       alu_w_we;
    logic       alu_m_we;
    logic       alu_zero;

    mlr_alu u_alu (
        .op        (instr_op),
        .acc       (acc_q),
        .mem       (mem_rdata),
        .imm       (instr_imm),
        .flags_in  (flags_q),
        .result    (alu_res),
        .flags_out (alu_flags),
        .w_we      (alu_w_we),
        .m_we      (alu_m_we),
        .zero_skip (alu_zero)
    );

    // ----------------------------------------------------------------
    // instruction acceptance and sequencing
    // ----------------------------------------------------------------
    wire logic accept   = instr_valid & ready_q;
    wire logic op_exit  = is_exit(instr_op);
    wire logic op_skip  = is_skip_op(instr_op) & alu_zero;
    // the prefetched word is dropped by spending one dummy cycle
    wire logic two_cyc  = op_exit | op_skip;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire logic [ADDR_W-1:0] reg_addr = paddr[ADDR_W-1:0];
    wire logic              hi_zero  = (paddr[31:ADDR_W] == '0);
    wire logic              setup    = psel & ~penable;
    wire logic              wr_acc   = psel & penable & pready_q
                                       & pwrite & ~pslverr_q;
    wire logic              wr_ctrl  = wr_acc & (reg_addr == REG_CTRL);
    wire logic              wr_accum = wr_acc & (reg_addr == REG_ACC);
    wire logic              wr_flags = wr_acc & (reg_addr == REG_FLAGS);

    logic [31:0] rd_mux;
    logic        rd_hit;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        rd_hit = hi_zero;
        if (reg_addr == REG_CTRL)
            rd_mux = {30'h0, gie_q, run_q};
        else if (reg_addr == REG_STATUS)
            rd_mux = {29'h0, gie_q, state_q == ST_DUMMY, ready_q};
        else if (reg_addr == REG_ACC)
            rd_mux = {24'h0, acc_q};
        else if (reg_addr == REG_FLAGS)
            rd_mux = {28'h0, flags_q};
        else if (reg_addr == REG_PC)
            rd_mux = {{(32-PC_W){1'b0}}, pc_q};
        else
            rd_hit = 1'b0;
    end

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        pc_d    = pc_q;
        acc_d   = wr_accum ? pwdata[7:0] : acc_q;
        flags_d = wr_flags ? pwdata[FLAG_W-1:0] : flags_q;
        run_d   = wr_ctrl ? pwdata[CTRL_RUN] : run_q;
        gie_d   = wr_ctrl ? pwdata[CTRL_GIE] : gie_q;
        case (state_q)
            ST_READY:
            begin
                if (accept)
                begin
                    if (op_exit)
                        pc_d = stack_top;
                    else if (op_skip)
                        pc_d = pc_q + PC_TWO;
                    else
                        pc_d = pc_q + PC_ONE;
                    if (alu_w_we)
                        acc_d = alu_res;
                    flags_d = alu_flags;
                    // hardware set beats a software clear
                    if (instr_op == OP_INTERRUPT_EXIT)
                        gie_d = 1'b1;
                    if (two_cyc)
                        state_d = ST_DUMMY;
                end
            end
            ST_DUMMY:
            begin
                state_d = ST_READY;
            end
            default:
            begin
                state_d = ST_READY;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_READY;
            pc_q    <= PC_RST;
            acc_q   <= ACC_RST;
            flags_q <= FLAGS_RST;
            gie_q   <= GIE_RST;
            run_q   <= RUN_RST;
            ready_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            pc_q    <= pc_d;
            acc_q   <= acc_d;
            flags_q <= flags_d;
            gie_q   <= gie_d;
            run_q   <= run_d;
            ready_q <= (state_d == ST_READY) & run_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_we_q    <= 1'b0;
            mem_wdata_q <= 8'h00;
            pop_q       <= 1'b0;
        end
        else
        begin
            mem_we_q    <= accept & alu_m_we;
            // zero between writes keeps the write bus quiet
            mem_wdata_q <= (accept & alu_m_we) ? alu_res : 8'h00;
            pop_q       <= accept & op_exit;
        end
    end

    // one wait-free access phase after every setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= setup;
            pslverr_q <= setup & ~rd_hit;
            prdata_q  <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign instr_ready = ready_q;
    assign mem_we      = mem_we_q;
    assign mem_wdata   = mem_wdata_q;
    assign stack_pop   = pop_q;
    assign pc          = pc_q;
    assign acc         = acc_q;
    assign flags       = flags_q;
    assign gie         = gie_q;

endmodule // mlr_exec
`default_nettype wire

// >>> verilog/mlr_pkg.sv
// mlr_pkg: shared constants and types of the move/logic/rotate/skip unit.
// assumes: included first; no tool switches needed.
package mlr_pkg;

    // ----------------------------------------------------------------
    // operation codes, delivered already decoded by the fetch stage
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_IDLE_INSTRUCTION  = 5'h00,
        OP_COPY_MEM_TO_W     = 5'h01,
        OP_COPY_IMM_TO_W     = 5'h02,
        OP_COPY_W_TO_MEM     = 5'h03,
        OP_OR_MEM            = 5'h04,
        OP_OR_IMM            = 5'h05,
        OP_OR_INTO_MEMORY    = 5'h06,
        OP_SUBROUTINE_EXIT   = 5'h07,
        OP_SUB_EXIT_VALUE    = 5'h08,
        OP_INTERRUPT_EXIT    = 5'h09,
        OP_ROT_L             = 5'h0A,
        OP_ROT_L_W           = 5'h0B,
        OP_ROT_LC            = 5'h0C,
        OP_ROT_LC_W          = 5'h0D,
        OP_ROT_R             = 5'h0E,
        OP_ROT_R_W           = 5'h0F,
        OP_ROT_RC            = 5'h10,
        OP_ROT_RC_W          = 5'h11,
        OP_SUB_BORROW        = 5'h12,
        OP_SUB_BORROW_MEM    = 5'h13,
        OP_DEC_SKIP_ZERO     = 5'h14,
        OP_DEC_W_SKIP_ZERO   = 5'h15
    } mlr_op_t;

    // ----------------------------------------------------------------
    // execution state, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_READY = 2'b01,
        ST_DUMMY = 2'b10
    } mlr_state_t;

    // ----------------------------------------------------------------
    // status flag positions
    // ----------------------------------------------------------------
    localparam int FLAG_W        = 4;
    localparam int FLAG_C        = 0;
    localparam int FLAG_AC       = 1;
    localparam int FLAG_Z        = 2;
    localparam int FLAG_OV       = 3;
    localparam int BYTE_MSB      = 7;
    localparam int NIB_W         = 4;

    // ----------------------------------------------------------------
    // apb register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int        ADDR_W       = 8;
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_STATUS  = 8'h04;
    localparam logic [7:0] REG_ACC     = 8'h08;
    localparam logic [7:0] REG_FLAGS   = 8'h0C;
    localparam logic [7:0] REG_PC      = 8'h10;
    localparam int CTRL_RUN      = 0;
    localparam int CTRL_GIE      = 1;
    localparam int STAT_READY    = 0;
    localparam int STAT_DUMMY    = 1;
    localparam int STAT_GIE      = 2;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] ACC_RST   = 8'h00;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic       RUN_RST   = 1'b1;
    localparam logic       GIE_RST   = 1'b0;

endpackage : mlr_pkg
